// ### bcr_top.sv
// Our own choice: register access over APB.
`include "bcr_consts.svh"
`default_nettype none
module bcr_top
(
  // apb slave
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [15:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output var  logic                     pready,
  output var  logic [31:0]              prdata,
  output var  logic                     pslverr,
  // transfer fifo and pixel stream from the drawing datapath, result pixel stream out
  input  wire logic [4:0]               fifo_used,
  input  wire bcr_pkg::bcr_pix_in_type  pix_in,
  output var  bcr_pkg::bcr_pix_out_type pix_out,
  // engine control towards the datapath
  output var  logic                     busy,
  output var  logic                     xfer_run,
  output var  bcr_pkg::bcr_op_type      op_sel,
  output var  bcr_pkg::bcr_addr_type    addr_info
);
  import bcr_pkg::*;

  typedef struct packed {
    logic            fmt16;
    logic [3:0]      rop;
    bcr_op_type      op;
    logic [20:0]     src;
    logic            busy;
    logic            stall;
    logic            run;
    bcr_pix_out_type pix;
    bcr_addr_type    ai;
    logic            ready;
    logic            err;
    logic [31:0]     rdata;
  } bcr_state_type;

  bcr_state_type s_q;
  bcr_state_type s_d;

  // one output bit for one pixel bit: the code is a truth table
  // indexed by {source, destination}
  function automatic logic [15:0] rop_apply(input logic [3:0] code,
                                            input logic [15:0] a,
                                            input logic [15:0] b,
                                            input logic wide);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = code[{a[i], b[i]}];
    end
    if (!wide)
    begin
      r[15:8] = 8'h00;
    end
    return r;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_transparent(input bcr_op_type o);
    return o == BCR_OP_TWRITE || o == BCR_OP_TMOVE ||
           o == BCR_OP_TPAT || o == BCR_OP_TCEXP ||
           o == BCR_OP_TMCEXP;
  endfunction

  function automatic logic is_pattern(input bcr_op_type o);
    return o == BCR_OP_PAT || o == BCR_OP_TPAT;
  endfunction

  function automatic logic uses_rop(input bcr_op_type o);
    return o == BCR_OP_WRITE || o == BCR_OP_MOVE_POS ||
           o == BCR_OP_MOVE_NEG || o == BCR_OP_PAT;
  endfunction

  function automatic logic [15:0] depth_mask(input logic [15:0] v,
                                             input logic wide);
    return wide ? v : {8'h00, v[7:0]};
  endfunction

  // pattern address split; 8 bpp keeps one more base bit than 16 bpp
  function automatic bcr_addr_type pat_split(input logic [20:0] a,
                                             input logic        wide);
    bcr_addr_type r;
    r = '0;
    r.fmt16      = wide;
    r.byte_align = a[0];
    if (wide)
    begin
      r.base  = {1'b0, a[`BCR_SRC_HI:`BCR_P16_BASE_LO]};
      r.line  = a[`BCR_P16_LINE_HI:`BCR_P16_LINE_LO];
      r.pixel = a[`BCR_P16_LINE_LO-1:0];
    end
    else
    begin
      r.base  = a[`BCR_SRC_HI:`BCR_P8_BASE_LO];
      r.line  = a[`BCR_P8_LINE_HI:`BCR_P8_LINE_LO];
      r.pixel = {1'b0, a[`BCR_P8_LINE_LO-1:0]};
    end
    return r;
  endfunction

  // read hysteresis: set at full, clear below the resume level and
  // hold in between, so the FIFO is never topped up
  function automatic logic stall_next(input logic       stall,
                                      input logic       run_on,
                                      input bcr_op_type o,
                                      input logic [4:0] used);
    logic r;
    r = stall;
    if (!run_on || o != BCR_OP_READ)
    begin
      r = 1'b0;
    end
    else if (used >= `BCR_FIFO_DEPTH)
    begin
      r = 1'b1;
    end
    else if (used < `BCR_FIFO_RESUME)
    begin
      r = 1'b0;
    end
    return r;
  endfunction

  // opaque write, both moves and opaque pattern fill go through the raster code; read
  // hands the destination on, the other operations their source
  function automatic logic [15:0] pix_result(input bcr_op_type  o,
                                             input logic [3:0]  code,
                                             input logic [15:0] sp,
                                             input logic [15:0] dp,
                                             input logic        wide);
    logic [15:0] r;
    r = sp;
    if (o == BCR_OP_READ)
    begin
      r = dp;
    end
    else if (uses_rop(o))
    begin
      r = rop_apply(code, sp, dp, wide);
    end
    return r;
  endfunction

  logic        setup;
  logic        access;
  logic        mapped;
  logic [31:0] ctrl_img;
  logic [31:0] stat_img;
  logic [31:0] cmd_img;
  logic [31:0] src_img;
  logic [31:0] wval;
  logic        start;
  logic [15:0] s_pix;
  logic [15:0] d_pix;
  logic [15:0] res;
  logic [4:0]  free_cnt;

  always_comb
  begin
    s_d      = s_q;
    setup    = psel && !penable;
    access   = psel && penable && s_q.ready;
    mapped   = paddr == `BCR_OFS_CTRL || paddr == `BCR_OFS_STAT ||
               paddr == `BCR_OFS_CMD || paddr == `BCR_OFS_SRC;
    free_cnt = 5'(`BCR_FIFO_DEPTH - fifo_used);
    ctrl_img = 32'h0000_0000;
    ctrl_img[`BCR_CTRL_FMT] = s_q.fmt16;
    stat_img = 32'h0000_0000;
    stat_img[`BCR_USED_HI:`BCR_USED_LO] = fifo_used;
    stat_img[`BCR_FREE_HI:`BCR_FREE_LO] = free_cnt;
    stat_img[`BCR_CTRL_EN] = s_q.busy;
    cmd_img  = 32'h0000_0000;
    cmd_img[`BCR_CMD_ROP_HI:`BCR_CMD_ROP_LO] = s_q.rop;
    cmd_img[`BCR_CMD_OP_HI:`BCR_CMD_OP_LO]   = s_q.op;
    src_img  = 32'h0000_0000;
    src_img[`BCR_SRC_HI:0] = s_q.src;
    wval     = 32'h0000_0000;
    start    = 1'b0;

    // answer one cycle after setup; reads are sampled at setup
    s_d.ready = setup;
    s_d.err   = setup && !mapped;
    if (setup)
    begin
      case (paddr)
        `BCR_OFS_CTRL: s_d.rdata = ctrl_img;
        `BCR_OFS_STAT: s_d.rdata = stat_img;
        `BCR_OFS_CMD:  s_d.rdata = cmd_img;
        `BCR_OFS_SRC:  s_d.rdata = src_img;
        default:       s_d.rdata = 32'h0000_0000;
      endcase
    end

    if (access && pwrite)
    begin
      case (paddr)
        `BCR_OFS_CTRL:
        begin
          wval    = wmerge(ctrl_img, pwdata, pstrb);
          s_d.fmt16 = wval[`BCR_CTRL_FMT];
          // enable is write only and never stored; reserved codes
          // would leave busy stuck, so they do not start
          start   = wval[`BCR_CTRL_EN] && pstrb[0] &&
                    s_q.op <= bcr_op_type'(`BCR_OP_LAST);
        end
        `BCR_OFS_CMD:
        begin
          wval    = wmerge(cmd_img, pwdata, pstrb);
          s_d.rop = wval[`BCR_CMD_ROP_HI:`BCR_CMD_ROP_LO];
          s_d.op  = bcr_op_type'(wval[`BCR_CMD_OP_HI:`BCR_CMD_OP_LO]);
        end
        `BCR_OFS_SRC:
        begin
          wval    = wmerge(src_img, pwdata, pstrb);
          s_d.src = wval[`BCR_SRC_HI:0];
        end
        default:
        begin
          wval = 32'h0000_0000;
        end
      endcase
    end

    // source selection for the boolean function
    s_pix = is_pattern(s_q.op) ? pix_in.pat : pix_in.src;
    s_pix = depth_mask(s_pix, s_q.fmt16);
    d_pix = depth_mask(pix_in.dst, s_q.fmt16);
    res   = pix_result(s_q.op, s_q.rop, s_pix, d_pix, s_q.fmt16);

    s_d.pix.valid = s_q.run && pix_in.valid;
    s_d.pix.pix   = res;
    // transparent modes drop pixels equal to the key colour
    s_d.pix.we    = s_q.run && pix_in.valid &&
                    !(is_transparent(s_q.op) &&
                      s_pix == depth_mask(pix_in.key, s_q.fmt16));

    // start wins over a completion in the same cycle
    if (start)
    begin
      s_d.busy = 1'b1;
    end
    else if (s_q.run && pix_in.valid && pix_in.last)
    begin
      s_d.busy = 1'b0;
    end
    // stall follows the next busy, so a read started on a full FIFO
    // moves nothing in its first cycle
    s_d.stall = stall_next(s_q.stall, s_d.busy, s_q.op, fifo_used);
    s_d.run = s_d.busy && !(s_q.op == BCR_OP_READ && s_d.stall);

    s_d.ai           = pat_split(s_q.src, s_q.fmt16);
    s_d.ai.start_bit = s_q.rop[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pready    = s_q.ready;
  assign prdata    = s_q.rdata;
  assign pslverr   = s_q.err;
  assign pix_out   = s_q.pix;
  assign busy      = s_q.busy;
  assign xfer_run  = s_q.run;
  assign op_sel    = s_q.op;
  assign addr_info = s_q.ai;
endmodule
`default_nettype wire

// ### bcr_consts.svh
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH
`define BCR_OFS_CTRL     16'h8000
`define BCR_OFS_STAT     16'h8004
`define BCR_OFS_CMD      16'h8008
`define BCR_OFS_SRC      16'h800C
`define BCR_CTRL_FMT     18
`define BCR_CTRL_EN      0
`define BCR_CMD_ROP_HI   19
`define BCR_CMD_ROP_LO   16
`define BCR_CMD_OP_HI    3
`define BCR_CMD_OP_LO    0
`define BCR_SRC_HI       20
`define BCR_CMD_RESET    32'h0000_0000
`define BCR_FIFO_DEPTH   5'h10
`define BCR_FIFO_RESUME  5'h0E
`define BCR_OP_LAST      4'hC
`define BCR_USED_HI      28
`define BCR_USED_LO      24
`define BCR_FREE_HI      20
`define BCR_FREE_LO      16
`define BCR_P8_LINE_HI   5
`define BCR_P8_LINE_LO   3
`define BCR_P8_BASE_LO   6
`define BCR_P16_LINE_HI  6
`define BCR_P16_LINE_LO  4
`define BCR_P16_BASE_LO  7
`endif

// ### bcr_pkg.sv
`default_nettype none
package bcr_pkg;
  typedef enum logic [3:0] {
    BCR_OP_WRITE, BCR_OP_READ, BCR_OP_MOVE_POS, BCR_OP_MOVE_NEG,
    BCR_OP_TWRITE, BCR_OP_TMOVE, BCR_OP_PAT, BCR_OP_TPAT,
    BCR_OP_CEXP, BCR_OP_TCEXP, BCR_OP_MCEXP, BCR_OP_TMCEXP,
    BCR_OP_SOLID, BCR_OP_RSV_D, BCR_OP_RSV_E, BCR_OP_RSV_F
  } bcr_op_type;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] pat;
    logic [15:0] key;
  } bcr_pix_in_type;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] pix;
  } bcr_pix_out_type;

  typedef struct packed {
    logic        fmt16;
    logic [14:0] base;
    logic [2:0]  line;
    logic [3:0]  pixel;
    logic        byte_align;
    logic [2:0]  start_bit;
  } bcr_addr_type;
endpackage
`default_nettype wire

// ### bcr_top_checker.sv
`include "bcr_consts.svh"
`default_nettype none
module bcr_top_checker import bcr_pkg::*;
(
  // apb
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [15:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic                     pready,
  // engine
  input wire logic [4:0]               fifo_used,
  input wire bcr_pkg::bcr_pix_in_type  pix_in,
  input wire bcr_pkg::bcr_pix_out_type pix_out,
  input wire logic                     busy,
  input wire logic                     xfer_run,
  input wire bcr_pkg::bcr_op_type      op_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cw;
  logic rd;
  assign cw = psel && penable && pready && pwrite;
  assign rd = busy && op_sel == BCR_OP_READ;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctl_go;
    cw && paddr == `BCR_OFS_CTRL && pwdata[0];
  endsequence
  // two sampled cycles at or above the resume level while stalled
  sequence s_held;
    (rd && !xfer_run && fifo_used >= 5'h0E) [*2];
  endsequence
  a_op_copy: assert property (
    cw && paddr == `BCR_OFS_CMD |=> op_sel == $past(pwdata[3:0]))
    else $error("op select not taken");
  a_start_busy: assert property (
    s_ctl_go ##0 op_sel <= 4'hC |=> busy) else $error("no start");
  a_rsv_idle: assert property (
    (!busy && op_sel > 4'hC) ##0 s_ctl_go |=> !busy)
    else $error("reserved op started");
  a_busy_done: assert property (
    busy && xfer_run && pix_in.valid && pix_in.last
    && !(cw && paddr == `BCR_OFS_CTRL) |=> !busy)
    else $error("busy after last pixel");
  a_pix_echo: assert property (
    xfer_run && pix_in.valid |=> pix_out.valid)
    else $error("pixel lost");
  a_full_stall: assert property (
    rd && fifo_used == 5'h10 |-> ##1 !xfer_run)
    else $error("no stall at full");
  a_full_start: assert property (
    s_ctl_go ##0 (op_sel == BCR_OP_READ && fifo_used == 5'h10)
    |=> !xfer_run) else $error("ran on a full FIFO");
  a_stall_hold: assert property (
    s_held |=> !xfer_run) else $error("refill above level");
  a_stall_resume: assert property (
    rd && !xfer_run && fifo_used < 5'h0E |-> ##[1:2] (xfer_run || !busy))
    else $error("no resume");
endmodule
`default_nettype wire

// ### bcr_apb_host.sv
`default_nettype none
module bcr_apb_host
(
  // apb master
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [15:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // request held whole until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] wd, output logic [31:0] q,
                      output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### blit_command_rop_decode_test.sv
`include "bcr_consts.svh"
`default_nettype none
module blit_command_rop_decode_test import bcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic            busy, xfer_run, er, fm;
  logic [15:0]     paddr, s, d, p, x;
  logic [31:0]     pwdata, prdata, q, sa;
  logic [3:0]      pstrb;
  logic [4:0]      fifo_used;
  bcr_pix_in_type  pix_in;
  bcr_pix_out_type pix_out;
  bcr_op_type      op_sel;
  bcr_addr_type    addr_info;
  int              n_errors, n_tests;
  bcr_top u_bcr_top
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fifo_used(fifo_used), .pix_in(pix_in), .pix_out(pix_out),
    .busy(busy), .xfer_run(xfer_run), .op_sel(op_sel),
    .addr_info(addr_info)
  );
  bcr_apb_host u_bcr_apb_host
  (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb)
  );
  function automatic logic [15:0] rop(logic [3:0] c, logic [15:0] a, b);
    return {16{c[3]}} & a & b | {16{c[2]}} & a & ~b
         | {16{c[1]}} & ~a & b | {16{c[0]}} & ~a & ~b;
  endfunction
  task automatic chk(input logic [31:0] v, e);
    n_tests++;
    if (v !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    u_bcr_apb_host.xfer(1'b1, a, v, q, er);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    u_bcr_apb_host.xfer(1'b0, a, 32'h0, q, er);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // start in the depth set by fm, present one last pixel, look at the echo
  task automatic px(input logic [15:0] k, input logic run);
    wr(`BCR_OFS_CTRL, {13'h0, fm, 17'h0, 1'b1});
    @(posedge pclk);
    pix_in <= {2'b11, s, d, p, k};
    @(posedge pclk);
    pix_in.valid <= 1'b0;
    #1;
    chk(pix_out.valid, run);
    chk(busy, 1'b0);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
  initial
  begin
    presetn = 1'b0;
    fifo_used = 5'h00;
    pix_in = '0;
    void'($urandom(32'hB3A9637D));
    fm = 1'b1;
    {s, d, p} = {$urandom, 16'($urandom)};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BCR_OFS_CMD, 32'h0);
    rd(`BCR_OFS_STAT, 32'h0010_0000);
    rd(16'h8040, 32'h0);
    chk(er, 1'b1);
    sa = $urandom;
    wr(`BCR_OFS_SRC, sa);
    rd(`BCR_OFS_SRC, sa & 32'h001F_FFFF);
    settle;
    chk(addr_info.line, sa[5:3]);
    chk(addr_info.pixel, sa[2:0]);
    chk(addr_info.byte_align, sa[0]);
    chk(addr_info.fmt16, 1'b0);
    chk(addr_info.base, sa[20:6]);
    wr(`BCR_OFS_CTRL, 32'h0004_0000);
    rd(`BCR_OFS_CTRL, 32'h0004_0000);
    settle;
    chk(addr_info.fmt16, 1'b1);
    chk(addr_info.base, sa[20:7]);
    chk(addr_info.line, sa[6:4]);
    chk(addr_info.pixel, sa[3:0]);
    for (int op = 0; op < 16; op++)
    begin
      wr(`BCR_OFS_CMD, op);
      px(16'h0, op < 13);
      chk(op_sel, op);
    end
    for (int o = 0; o < 4; o++)
      for (int c = 0; c < 16; c++)
      begin
        s = 16'($urandom);
        d = 16'($urandom);
        p = 16'($urandom);
        fm = o[1];
        wr(`BCR_OFS_CMD, {12'h000, c[3:0], 12'h000, 4'(o[0] * 6)});
        px(~s, 1'b1);
        x = rop(c[3:0], o[0] ? p : s, d) & {{8{fm}}, 8'hFF};
        chk(pix_out.pix, x);
        chk(pix_out.we, 1'b1);
        chk(addr_info.start_bit, c[2:0]);
      end
    wr(`BCR_OFS_CMD, 32'h4);
    rd(`BCR_OFS_CMD, 32'h4);
    px(s, 1'b1);
    chk(pix_out.we, 1'b0);
    wr(`BCR_OFS_CMD, 32'h1);
    fifo_used <= 5'h10;
    wr(`BCR_OFS_CTRL, 32'h0004_0001);
    repeat (3) @(posedge pclk);
    #1 chk(xfer_run, 1'b0);
    rd(`BCR_OFS_STAT, 32'h1000_0001);
    fifo_used <= 5'h0E + 5'($urandom_range(1));
    repeat (4) @(posedge pclk);
    #1 chk(xfer_run, 1'b0);
    fifo_used <= 5'h0D;
    repeat (3) @(posedge pclk);
    #1 chk(xfer_run, 1'b1);
    px(16'h0, 1'b1);
    tally_and_finish;
  end
endmodule
bind bcr_top bcr_top_checker u_bcr_top_checker
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .fifo_used(fifo_used), .pix_in(pix_in), .pix_out(pix_out),
  .busy(busy), .xfer_run(xfer_run), .op_sel(op_sel)
);
`default_nettype wire
